// ===== hw/gpp_port.sv
// gpp_port: one eight-pin general-purpose port behind an AHB-Lite slave
// assumes: pad cell does the tri-state from PAD_OE, pullup from PAD_PULLUP,
// and an always-on catcher toggles ASYNC_TOGGLE[n] on async-capable pins
//
// Overview of operation
// - up to eight pins, bit n per pin
// - pin levels synchronised, readable any direction
// - reset tri-states outputs, inputs stay enabled
// - pin n config at offset 0x10 plus n
// - direction set strobe sets chosen bits
// - direction clear strobe clears chosen bits
// - direction toggle strobe inverts chosen bits
// - output set strobe sets chosen bits
// - output clear strobe clears chosen bits
// - output toggle or input write inverts output
// - direction zero disables driver, one drives
// - polarity flip inverts driven and sensed value
// - polarity change makes an internal edge
// - resistor enable bit turns on pullup
// - sense select picks condition and enable
// - sensed condition sets flag, request holds
// - sync pins wake only any-edge or low
// - sync pins need full-cycle pulses
// - three-cycle dead time on sync pins
// - alias registers act like regular ones
// - peripherals may override pins individually
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module gpp_port
   import gpp_pkg::*;
#(
   parameter int NPINS = 8,
   parameter logic [7:0] ASYNC_MASK = 8'h04
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // pads
   input wire logic [7:0] PAD_IN,
   input wire logic [7:0] ASYNC_TOGGLE,
   output logic [7:0] PAD_OUT,
   output logic [7:0] PAD_OE,
   output logic [7:0] PAD_PULLUP,
   // peripheral side
   input wire gpp_ovr_s OVR,
   output logic [7:0] PIN_VALUE,
   output logic [7:0] WAKE_EN,
   output logic IRQ
);

   logic [1:0] rst_sync_q;
   logic rst_n;
   gpp_bus_e bus_q;
   logic wr_pend_q;
   logic [7:0] wr_idx_q;
   logic [7:0] rd_idx_q;
   logic [7:0] wd;
   logic [7:0] dir_q;
   logic [7:0] out_q;
   logic [7:0] flags_q;
   logic [7:0] cfg_q [8];
   logic [7:0] in_q;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] at1_q;
   logic [7:0] at2_q;
   logic [7:0] at3_q;
   logic [7:0] in_val;
   logic [7:0] flag_set;
   logic [7:0] sense_on;
   logic [7:0] wake_d;
   logic [7:0] inv;
   logic [1:0] dead_q [8];
   logic [7:0] rd_mux;
   logic addr_ok;

   // reset release through two flops; assertion stays asynchronous
   // the clear reaches every flop at once, so the pads go quiet with no clock
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
   assign wd = HWDATA[7:0];

   // bus slave: writes take no wait, reads take one so data is fresh
   // hsize is ignored: every register is one aligned word in bits 7:0
   // a read stalls one cycle so a write just ahead of it is already seen
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         bus_q <= ST_IDLE;
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         rd_idx_q <= 8'h00;
         HREADYOUT <= 1'b1;
         HRDATA <= 32'h0000_0000;
      end else begin
         case (bus_q)
            ST_IDLE: begin
               wr_pend_q <= addr_ok && HWRITE;
               wr_idx_q <= HADDR[9:2];
               if (addr_ok && !HWRITE) begin
                  rd_idx_q <= HADDR[9:2];
                  HREADYOUT <= 1'b0;
                  bus_q <= ST_RD_WAIT;
               end
            end
            ST_RD_WAIT: begin
               wr_pend_q <= 1'b0;
               HRDATA <= {24'h00_0000, rd_mux};
               HREADYOUT <= 1'b1;
               bus_q <= ST_IDLE;
            end
            default: begin
               wr_pend_q <= 1'b0;
               HREADYOUT <= 1'b1;
               bus_q <= ST_IDLE;
            end
         endcase
      end
   end

   // every transfer answers okay, unmapped ones included
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         HRESP <= HRESP_OKAY;
      end else begin
         HRESP <= HRESP_OKAY;
      end
   end

   // read mux; strobe registers read back the register they modify
   // unmapped indices read zero; their writes fall through every decoder
   always_comb begin
      rd_mux = 8'h00;
      case (rd_idx_q)
         IDX_DIR, IDX_DIR_SET, IDX_DIR_CLR, IDX_DIR_TGL, IDX_A_DIR: rd_mux = dir_q;
         IDX_OUT, IDX_OUT_SET, IDX_OUT_CLR, IDX_OUT_TGL, IDX_A_OUT: rd_mux = out_q;
         IDX_IN, IDX_A_IN: rd_mux = in_q;
         IDX_FLAGS, IDX_A_FLAGS: rd_mux = flags_q;
         default: begin
            if (rd_idx_q[7:3] == IDX_CFG0[7:3]) begin
               rd_mux = cfg_q[rd_idx_q[2:0]];
            end
         end
      endcase
   end

   // direction register and its strobes; alias writes land identically
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= RST_DIR;
      end else if (wr_pend_q) begin
         case (wr_idx_q)
            IDX_DIR, IDX_A_DIR: dir_q <= wd;
            IDX_DIR_SET: dir_q <= dir_q | wd;
            IDX_DIR_CLR: dir_q <= dir_q & ~wd;
            IDX_DIR_TGL: dir_q <= dir_q ^ wd;
            default: dir_q <= dir_q;
         endcase
      end
   end

   // output-value register and its strobes
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= RST_OUT;
      end else if (wr_pend_q) begin
         case (wr_idx_q)
            IDX_OUT, IDX_A_OUT: out_q <= wd;
            IDX_OUT_SET: out_q <= out_q | wd;
            IDX_OUT_CLR: out_q <= out_q & ~wd;
            IDX_OUT_TGL, IDX_IN, IDX_A_IN: out_q <= out_q ^ wd;
            default: out_q <= out_q;
         endcase
      end
   end

   // per-pin config words, one per pin
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) begin
            cfg_q[i] <= RST_CFG;
         end
      end else if (wr_pend_q && (wr_idx_q[7:3] == IDX_CFG0[7:3])) begin
         cfg_q[wr_idx_q[2:0]] <= wd;
      end
   end

   // event flags: a same-cycle hit beats the software clear
   // limitation: low-level sensing re-raises the flag while the pin stays low
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= RST_FLAGS;
      end else if (wr_pend_q && (wr_idx_q == IDX_FLAGS || wr_idx_q == IDX_A_FLAGS)) begin
         flags_q <= (flags_q & ~wd) | flag_set;
      end else begin
         flags_q <= flags_q | flag_set;
      end
   end

   // pad and catcher synchronisers; the pad's second stage and the catcher's second and third stages feed logic
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
         at1_q <= 8'h00;
         at2_q <= 8'h00;
         at3_q <= 8'h00;
      end else begin
         sync1_q <= PAD_IN;
         sync2_q <= sync1_q;
         at1_q <= ASYNC_TOGGLE;
         at2_q <= at1_q;
         at3_q <= at2_q;
      end
   end

   // per-pin sensing; pins above NPINS stay idle
   // input-off forces the sensed value low; the synchroniser keeps running,
   // traded against clock gating so no enable is needed on any flop
   // bit n governs pin n
   for (genvar n = 0; n < 8; n++) begin : g_pin
      logic [2:0] sel;
      logic hit;
      logic async_hit;
      logic is_async;
      assign sel = cfg_q[n][CFG_SEL_LSB +: CFG_SEL_W];
      assign inv[n] = cfg_q[n][CFG_INV_BIT];
      assign is_async = ASYNC_MASK[n];
      assign sense_on[n] = (n < NPINS) && (sel == SEL_ANY_EDGE || sel == SEL_RISE
                           || sel == SEL_FALL || sel == SEL_LOW);
      assign in_val[n] = (n < NPINS) && (sel != SEL_IN_OFF) && (sync2_q[n] ^ inv[n]);
      // flip edge seen here, since inversion follows the synchroniser
      always_comb begin
         case (sel)
            SEL_ANY_EDGE: hit = in_val[n] ^ in_q[n];
            SEL_RISE: hit = in_val[n] & ~in_q[n];
            SEL_FALL: hit = ~in_val[n] & in_q[n];
            SEL_LOW: hit = ~in_val[n];
            default: hit = 1'b0;
         endcase
      end
      assign async_hit = is_async && (at2_q[n] ^ at3_q[n]);
      assign flag_set[n] = sense_on[n] && ((hit && (dead_q[n] == 2'h0)) || async_hit);
      assign wake_d[n] = sense_on[n] && (is_async || sel == SEL_ANY_EDGE || sel == SEL_LOW);
      // dead-time count; async pins skip it since the catcher spaces their events
      always_ff @(posedge CLK_SYS or negedge rst_n) begin
         if (!rst_n) begin
            dead_q[n] <= 2'h0;
         end else if (flag_set[n] && !is_async) begin
            dead_q[n] <= DEAD_CYC;
         end else if (dead_q[n] != 2'h0) begin
            dead_q[n] <= dead_q[n] - 2'h1;
         end
      end
   end

   // sampled input value; also the previous value for edge sensing
   // reset low like the synchroniser, so no false edge follows reset
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         in_q <= 8'h00;
      end else begin
         in_q <= in_val;
      end
   end

   // pad drive; async reset holds the driver off even without a clock
   // override and direction both pass one flop, so pads move one edge after a write
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         PAD_OE <= 8'h00;
         PAD_OUT <= 8'h00;
         PAD_PULLUP <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            PAD_OE[i] <= (i < NPINS) && (OVR.oe_take[i] ? OVR.oe[i] : dir_q[i]);
            PAD_OUT[i] <= (OVR.out_take[i] ? OVR.out[i] : out_q[i]) ^ inv[i];
            PAD_PULLUP[i] <= (i < NPINS) && cfg_q[i][CFG_PU_BIT];
         end
      end
   end

   // request, wake qualifiers and event/peripheral view of the pins
   // wake itself happens outside with the clock stopped; this only qualifies pins
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         IRQ <= 1'b0;
         WAKE_EN <= 8'h00;
         PIN_VALUE <= 8'h00;
      end else begin
         IRQ <= |(flags_q & sense_on);
         WAKE_EN <= wake_d;
         PIN_VALUE <= in_val;
      end
   end

endmodule // gpp_port

`default_nettype wire

// ===== shared/gpp_pkg.sv
// gpp_pkg: constants and types for the general-purpose pin port
// assumes: 32-bit AHB-Lite register bus, one register per aligned word
package gpp_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_DIR     = 8'h00;
   localparam logic [7:0] IDX_DIR_SET = 8'h01;
   localparam logic [7:0] IDX_DIR_CLR = 8'h02;
   localparam logic [7:0] IDX_DIR_TGL = 8'h03;
   localparam logic [7:0] IDX_OUT     = 8'h04;
   localparam logic [7:0] IDX_OUT_SET = 8'h05;
   localparam logic [7:0] IDX_OUT_CLR = 8'h06;
   localparam logic [7:0] IDX_OUT_TGL = 8'h07;
   localparam logic [7:0] IDX_IN      = 8'h08;
   localparam logic [7:0] IDX_FLAGS   = 8'h09;
   localparam logic [7:0] IDX_CFG0    = 8'h10;
   // bit-access alias of direction, output, input and flags
   localparam logic [7:0] IDX_A_DIR   = 8'h20;
   localparam logic [7:0] IDX_A_OUT   = 8'h21;
   localparam logic [7:0] IDX_A_IN    = 8'h22;
   localparam logic [7:0] IDX_A_FLAGS = 8'h23;

   // per-pin config fields
   localparam int CFG_INV_BIT = 7;
   localparam int CFG_PU_BIT = 3;
   localparam int CFG_SEL_LSB = 0;
   localparam int CFG_SEL_W = 3;

   // sense_select codes
   localparam logic [2:0] SEL_NO_INT = 3'h0;
   localparam logic [2:0] SEL_ANY_EDGE = 3'h1;
   localparam logic [2:0] SEL_RISE = 3'h2;
   localparam logic [2:0] SEL_FALL = 3'h3;
   localparam logic [2:0] SEL_IN_OFF = 3'h4;
   localparam logic [2:0] SEL_LOW = 3'h5;

   // reset values
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_OUT = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h00;

   // sync sensing dead time after a raised flag, in clock cycles
   localparam logic [1:0] DEAD_CYC = 2'h3;

   // ahb transfer type and response
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // peripheral takeover of the pins, one bit per pin
   typedef struct packed {
      logic [7:0] oe_take;
      logic [7:0] oe;
      logic [7:0] out_take;
      logic [7:0] out;
   } gpp_ovr_s;

   // bus slave states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RD_WAIT = 2'b10
   } gpp_bus_e;

endpackage

// ===== test/gpp_pad_model.sv
// gpp_pad_model: the board around the eight pins
// assumes: ext is the level that far-side drivers put on undriven pins
`timescale 1ns/100ps
`default_nettype none
module gpp_pad_model (
   // from the port
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pullup,
   // far side
   input wire logic [7:0] ext,
   output logic [7:0] pad_in
);
   // the port's driver wins, then the pullup, then the far side
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | ext));
endmodule // gpp_pad_model
`default_nettype wire

// ===== test/gpp_port_props.sv
// gpp_port_props: bus and pin timing checks on the port
// assumes: one slave, so HREADY is HREADYOUT
`timescale 1ns/100ps
`default_nettype none
module gpp_port_props
   import gpp_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // bus
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic [31:0] HRDATA,
   // pins
   input wire logic [7:0] PAD_OE,
   input wire logic [7:0] PAD_PULLUP,
   input wire gpp_ovr_s OVR,
   input wire logic IRQ
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   logic tk;
   logic [2:0] age_q;
   logic [7:0] take_q, take2_q, on_q;
   assign tk = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
   // cycles since a write; pullups may only move soon after one, drivers also during a takeover
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) age_q <= 3'h7;
      else if (tk && HWRITE) age_q <= 3'h0;
      else if (age_q != 3'h7) age_q <= age_q + 3'h1;
   end
   // takeover masks of the last two cycles
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) {take_q, take2_q, on_q} <= 24'h0;
      else {take_q, take2_q, on_q} <= {OVR.oe_take, take_q, OVR.oe};
   end
   chk_read_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait is not one cycle");
   chk_byte_wide: assert property (HREADYOUT |-> HRDATA[31:8] == 24'h0)
      else $error("read data above bit 7");
   chk_rdata_hold: assert property ($changed(HRDATA) |-> !$past(HREADYOUT))
      else $error("read data moved outside a read");
   chk_reset_tristate: assert property ($rose(RSTN) |-> (PAD_OE == 8'h00) [*2])
      else $error("pin driven after reset");
   chk_take_drive: assert property (take_q != 8'h00 |-> (PAD_OE & take_q) == (on_q & take_q))
      else $error("takeover enable not applied");
   chk_oe_cause: assert property ($changed(PAD_OE) |-> age_q < 3'h4 || (take_q | take2_q) != 8'h00)
      else $error("driver moved without cause");
   chk_pull_cause: assert property ($changed(PAD_PULLUP) |-> age_q < 3'h4)
      else $error("pullup moved without a write");
   chk_irq_clear: assert property ($fell(IRQ) |-> age_q < 3'h5)
      else $error("request dropped without a write");
endmodule // gpp_port_props
bind gpp_port gpp_port_props chk (.CLK_SYS, .RSTN, .HSEL, .HTRANS, .HWRITE, .HREADY,
   .HREADYOUT, .HRDATA, .PAD_OE, .PAD_PULLUP, .OVR, .IRQ);
`default_nettype wire

// ===== test/testbench.sv
// testbench: ahb-lite master, pad far side and reference model
// assumes: pad model and bound checker compiled before it
`timescale 1ns/100ps
`default_nettype none
module testbench
   import gpp_pkg::*;
;
   logic CLK_SYS = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, HREADYOUT, HRESP, IRQ;
   logic [1:0] HTRANS = 2'h0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rnd = 32'h4b88242f;
   logic [7:0] PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP, PIN_VALUE, WAKE_EN, r;
   logic [7:0] ext = 8'h00, atg = 8'h00, dir = 8'h00, out = 8'h00, inv = 8'h00, pu = 8'h00;
   logic [7:0] tab [11] = '{IDX_DIR_SET, IDX_DIR_CLR, IDX_DIR_TGL, IDX_OUT_SET,
      IDX_OUT_CLR, IDX_OUT_TGL, IDX_IN, IDX_A_DIR, IDX_A_OUT, IDX_A_IN, IDX_OUT};
   gpp_ovr_s OVR = '0;
   int mismatches = 0, cmp_count = 0, cyc = 0;
   gpp_port uut (.CLK_SYS, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
      .HREADY(HREADYOUT), .HREADYOUT, .HRESP, .HRDATA, .PAD_IN, .ASYNC_TOGGLE(atg),
      .PAD_OUT, .PAD_OE, .PAD_PULLUP, .OVR, .PIN_VALUE, .WAKE_EN, .IRQ);
   gpp_pad_model pads (.pad_out(PAD_OUT), .pad_oe(PAD_OE), .pad_pullup(PAD_PULLUP),
      .ext, .pad_in(PAD_IN));
   // 100 MHz clock
   always #5 CLK_SYS = ~CLK_SYS;
   // hang guard: the run needs under a thousand cycles
   always @(posedge CLK_SYS) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // what the port should sense once the pins settle
   function automatic logic [7:0] sensed();
      return ((dir & (out ^ inv)) | (~dir & (pu | ext))) ^ inv;
   endfunction
   task automatic final_report();
      $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(posedge CLK_SYS);
      HSEL <= 1'b1;
      HTRANS <= HTRANS_NONSEQ;
      HWRITE <= w;
      HADDR <= {22'h0, i, 2'b00};
      do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= {24'h0, d};
      do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
      r = HRDATA[7:0];
   endtask
   // write and follow it in the model
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      bus(1'b1, i, d);
      case (i)
         IDX_DIR, IDX_A_DIR: dir = d;
         IDX_DIR_SET: dir = dir | d;
         IDX_DIR_CLR: dir = dir & ~d;
         IDX_DIR_TGL: dir = dir ^ d;
         IDX_OUT, IDX_A_OUT: out = d;
         IDX_OUT_SET: out = out | d;
         IDX_OUT_CLR: out = out & ~d;
         IDX_OUT_TGL, IDX_IN, IDX_A_IN: out = out ^ d;
         default: begin
            if (i[7:3] == 5'h02) begin
               inv[i[2:0]] = d[CFG_INV_BIT];
               pu[i[2:0]] = d[CFG_PU_BIT];
            end
         end
      endcase
   endtask
   // registers read back through strobe places and the input alias, pins compared
   task automatic chk_regs();
      bus(1'b0, IDX_DIR_CLR, 8'h00);
      cmp(r, dir);
      bus(1'b0, IDX_OUT_SET, 8'h00);
      cmp(r, out);
      bus(1'b0, IDX_A_IN, 8'h00);
      cmp(r, sensed());
      cmp(PIN_VALUE, sensed());
      cmp(PAD_OE, dir);
      cmp(PAD_OUT & dir, (out ^ inv) & dir);
      cmp(PAD_PULLUP, pu);
      cmp({7'h0, HRESP}, {7'h0, HRESP_OKAY});
   endtask
   task automatic chk_flags(input logic e);
      bus(1'b0, IDX_A_FLAGS, 8'h00);
      cmp(r, {6'h0, e, 1'b0});
      cmp({7'h0, IRQ}, {7'h0, e});
   endtask
   initial begin
      repeat (20) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      cmp(PAD_OE, RST_DIR);
      bus(1'b0, IDX_FLAGS, 8'h00);
      cmp(r, RST_FLAGS);
      chk_regs();
      $display("test reset done");
      wr(IDX_CFG0 + 8'h03, 8'h88);
      bus(1'b0, IDX_CFG0 + 8'h03, 8'h00);
      cmp(r, 8'h88);
      // random strobes and far-side levels
      for (int k = 0; k < 33; k++) begin
         rnd = lfsr(rnd);
         ext <= rnd[15:8];
         wr(tab[k % 11], rnd[7:0]);
         chk_regs();
      end
      wr(8'h0a, 8'hff);
      bus(1'b0, 8'h0a, 8'h00);
      cmp(r, 8'h00);
      $display("test strobes done");
      // a peripheral takes pin 7 and drives it high
      OVR <= 32'h80808080;
      repeat (3) @(posedge CLK_SYS);
      cmp(PAD_OE, dir | 8'h80);
      cmp({7'h0, PAD_OUT[7]}, 8'h01);
      OVR <= '0;
      chk_regs();
      wr(IDX_DIR, 8'h00);
      // every sense code on pin 1: clear, fall, then rise
      for (int s = 0; s < 8; s++) begin
         ext <= 8'h02;
         wr(IDX_CFG0 + 8'h01, 8'(s));
         wr(IDX_FLAGS, 8'hff);
         chk_flags(1'b0);
         cmp({7'h0, WAKE_EN[1]}, {7'h0, s == 1 || s == 5});
         cmp({7'h0, PIN_VALUE[1]}, {7'h0, s != 4});
         ext <= 8'h00;
         repeat (8) @(posedge CLK_SYS);
         chk_flags(s == 1 || s == 3 || s == 5);
         ext <= 8'h02;
         repeat (8) @(posedge CLK_SYS);
         chk_flags(s == 1 || s == 2 || s == 3 || s == 5);
      end
      wr(IDX_CFG0 + 8'h01, 8'(SEL_ANY_EDGE));
      wr(IDX_FLAGS, 8'hff);
      // second edge one cycle later falls in the dead time
      ext <= 8'h00;
      @(posedge CLK_SYS);
      ext <= 8'h02;
      wr(IDX_FLAGS, 8'h02);
      chk_flags(1'b0);
      wr(IDX_CFG0 + 8'h01, 8'h80 | SEL_ANY_EDGE);
      repeat (4) @(posedge CLK_SYS);
      chk_flags(1'b1);
      // alias write clears the flag like the regular one
      wr(IDX_A_FLAGS, 8'hff);
      wr(IDX_CFG0 + 8'h02, 8'(SEL_RISE));
      atg <= 8'h04;
      repeat (4) @(posedge CLK_SYS);
      bus(1'b0, IDX_FLAGS, 8'h00);
      cmp(r, 8'h04);
      $display("test sensing done");
      final_report();
   end
endmodule // testbench
`default_nettype wire
